//--- hdl/dclf_pkg.sv
// Package for the data cache line fill block.
// Assumes a single clock domain and an APB register bus.
package dclf_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MISS_ADDR = 8'h08;
	localparam logic [7:0] OFS_FILL_DATA = 8'h0c;
	localparam logic [7:0] OFS_CONFIG = 8'h10;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_BURST_BIT = 1;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;
	// ----------------------------------------
	// Reset values and limits
	// ----------------------------------------
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int CACHE_MIN_BYTES = 512;
	localparam int CACHE_MAX_BYTES = 65536;
	localparam int WORD_BYTES = 4;
	localparam int LINE_WORDS_MAX = 8;
	typedef enum {ST_IDLE, ST_REQ, ST_BEAT} dclf_state_t;
endpackage

//--- hdl/dclf_top.sv
// Data cache line fill engine with APB control and a word-wide fill bus master.
// Assumes the memory slave answers with a valid strobe per word, same clock.
//
// Overview of operation
// - Cache size parameter, 512 B to 64 KB
// - Line length is 4, 16 or 32
// - No cache and a coupled port: data port may vanish
// - Optional burst line fills
// - Four-byte lines always use single transfers
// - Burst of 4 or 8 words
// - Fill starts at line-aligned base, ascending
// - Zero to four tightly coupled ports
`timescale 1ns/1ns
`default_nettype none
module dclf_top #(
	parameter int CACHE_BYTES = 4096,
	parameter int LINE_BYTES = 32,
	parameter bit BURST_EN = 1'b1,
	parameter bit OMIT_DATA_MASTER = 1'b0,
	parameter int TC_PORT_COUNT = 1
) (
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	output logic MEM_REQ_OUT,
	output logic [31:0] MEM_ADDR_OUT,
	output logic [3:0] MEM_BURST_LEN_OUT,
	input wire logic MEM_ACK_IN,
	input wire logic MEM_VALID_IN,
	input wire logic [31:0] MEM_RDATA_IN
);
	// ----------------------------------------
	// Build-time checks
	// ----------------------------------------
	localparam int LINE_WORDS = LINE_BYTES / dclf_pkg::WORD_BYTES;
	localparam bit USE_BURST = BURST_EN && (LINE_BYTES > dclf_pkg::WORD_BYTES);
	localparam logic [3:0] BEAT_LEN = USE_BURST ? 4'(LINE_WORDS) : 4'h1;
	localparam logic [31:0] LINE_MASK = ~32'(LINE_BYTES - 1);
	initial begin
		if (CACHE_BYTES != 0 && (CACHE_BYTES < dclf_pkg::CACHE_MIN_BYTES ||
			CACHE_BYTES > dclf_pkg::CACHE_MAX_BYTES)) begin
			$error("Bad cache size");
		end
		if (LINE_BYTES != 4 && LINE_BYTES != 16 && LINE_BYTES != 32) begin
			$error("Bad line size");
		end
		if (TC_PORT_COUNT < 0 || TC_PORT_COUNT > 4) begin
			$error("Bad port count");
		end
		if (OMIT_DATA_MASTER && (CACHE_BYTES != 0 || TC_PORT_COUNT < 1)) begin
			$error("Omitted master needs no cache and a coupled port");
		end
	end
	// ----------------------------------------
	// State
	// ----------------------------------------
	dclf_pkg::dclf_state_t state_reg, state_next;
	logic burst_reg, burst_next;
	logic done_reg, done_next;
	logic [31:0] miss_reg, miss_next;
	logic [31:0] addr_reg, addr_next;
	logic [2:0] slot_reg, slot_next;
	logic [2:0] left_reg, left_next;
	logic [31:0] line_reg [dclf_pkg::LINE_WORDS_MAX];
	logic [31:0] line_next [dclf_pkg::LINE_WORDS_MAX];
	logic [2:0] rd_sel_reg, rd_sel_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic req_reg, req_next;
	logic [3:0] blen_reg, blen_next;
	logic setup;
	logic start;

	assign setup = PSEL_IN && !PENABLE_IN && !pready_reg;
	assign start = setup && PWRITE_IN && PADDR_IN == dclf_pkg::OFS_CTRL &&
		PWDATA_IN[dclf_pkg::CTRL_START_BIT] && !OMIT_DATA_MASTER;

	// ----------------------------------------
	// Bus slave and fill sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		burst_next = burst_reg;
		done_next = done_reg;
		miss_next = miss_reg;
		addr_next = addr_reg;
		slot_next = slot_reg;
		left_next = left_reg;
		line_next = line_reg;
		rd_sel_next = rd_sel_reg;
		prdata_next = prdata_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		req_next = req_reg;
		blen_next = blen_reg;
		if (setup) begin
			pready_next = 1'b1;
			prdata_next = 32'h0000_0000;
			unique case (PADDR_IN)
				dclf_pkg::OFS_CTRL: begin
					if (PWRITE_IN) begin
						burst_next = PWDATA_IN[dclf_pkg::CTRL_BURST_BIT];
					end
					prdata_next[dclf_pkg::CTRL_BURST_BIT] = burst_reg;
				end
				dclf_pkg::OFS_STATUS: begin
					prdata_next[dclf_pkg::STATUS_BUSY_BIT] = state_reg != dclf_pkg::ST_IDLE;
					prdata_next[dclf_pkg::STATUS_DONE_BIT] = done_reg;
					prdata_next[6:4] = slot_reg;
				end
				dclf_pkg::OFS_MISS_ADDR: begin
					if (PWRITE_IN && state_reg == dclf_pkg::ST_IDLE) begin
						miss_next = PWDATA_IN;
					end
					prdata_next = miss_reg;
				end
				dclf_pkg::OFS_FILL_DATA: begin
					if (PWRITE_IN) begin
						rd_sel_next = PWDATA_IN[2:0];
					end
					prdata_next = line_reg[rd_sel_reg];
				end
				dclf_pkg::OFS_CONFIG: begin
					prdata_next = {12'h000, 4'(TC_PORT_COUNT), BEAT_LEN,
						6'(LINE_BYTES), 6'(CACHE_BYTES >> 10)};
				end
				default: pslverr_next = 1'b1;
			endcase
		end
		unique case (state_reg)
			dclf_pkg::ST_IDLE: begin
				if (start) begin
					done_next = 1'b0;
					state_next = dclf_pkg::ST_REQ;
					slot_next = 3'h0;
					req_next = 1'b1;
					if (burst_next && USE_BURST) begin
						addr_next = miss_reg & LINE_MASK;
						blen_next = BEAT_LEN;
						left_next = 3'(LINE_WORDS - 1);
					end else begin
						addr_next = miss_reg & LINE_MASK;
						blen_next = 4'h1;
						left_next = 3'(LINE_WORDS - 1);
					end
				end
			end
			dclf_pkg::ST_REQ: begin
				if (MEM_ACK_IN) begin
					req_next = 1'b0;
					state_next = dclf_pkg::ST_BEAT;
				end
			end
			dclf_pkg::ST_BEAT: begin
				if (MEM_VALID_IN) begin
					line_next[slot_reg] = MEM_RDATA_IN;
					slot_next = slot_reg + 3'h1;
					addr_next = addr_reg + 32'h4;
					if (left_reg == 3'h0) begin
						state_next = dclf_pkg::ST_IDLE;
						done_next = 1'b1;
					end else begin
						left_next = left_reg - 3'h1;
						if (blen_reg == 4'h1) begin
							state_next = dclf_pkg::ST_REQ;
							req_next = 1'b1;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLOCK_IN) begin
		if (!RSTN_IN) begin
			state_reg <= dclf_pkg::ST_IDLE;
			burst_reg <= dclf_pkg::CTRL_RESET[dclf_pkg::CTRL_BURST_BIT];
			done_reg <= 1'b0;
			miss_reg <= 32'h0000_0000;
			addr_reg <= 32'h0000_0000;
			slot_reg <= 3'h0;
			left_reg <= 3'h0;
			for (int i = 0; i < dclf_pkg::LINE_WORDS_MAX; i++) begin
				line_reg[i] <= 32'h0000_0000;
			end
			rd_sel_reg <= 3'h0;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			req_reg <= 1'b0;
			blen_reg <= 4'h1;
		end else begin
			state_reg <= state_next;
			burst_reg <= burst_next;
			done_reg <= done_next;
			miss_reg <= miss_next;
			addr_reg <= addr_next;
			slot_reg <= slot_next;
			left_reg <= left_next;
			line_reg <= line_next;
			rd_sel_reg <= rd_sel_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			req_reg <= req_next;
			blen_reg <= blen_next;
		end
	end

	assign PRDATA_OUT = prdata_reg;
	assign PREADY_OUT = pready_reg;
	assign PSLVERR_OUT = pslverr_reg;
	assign MEM_REQ_OUT = req_reg;
	assign MEM_ADDR_OUT = addr_reg;
	assign MEM_BURST_LEN_OUT = blen_reg;
endmodule
`default_nettype wire

//--- bench/dclf_top_asserts.sv
// Port checker for the fill engine.
// Assumes it is bound into dclf_top.
`timescale 1ns/1ns
`default_nettype none
module dclf_top_asserts #(parameter int LINE_BYTES = 32) (
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic MEM_REQ_OUT,
	input wire logic [31:0] MEM_ADDR_OUT,
	input wire logic [3:0] MEM_BURST_LEN_OUT,
	input wire logic MEM_ACK_IN,
	input wire logic MEM_VALID_IN
);
	localparam int W = LINE_BYTES / 4;
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RSTN_IN);
	chk_apb_answer: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
		else $error("apb answer late");
	chk_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready not a pulse");
	chk_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
		else $error("error without ready");
	chk_req_hold: assert property (
		MEM_REQ_OUT && !MEM_ACK_IN |=> MEM_REQ_OUT && $stable(MEM_ADDR_OUT))
		else $error("request dropped");
	chk_req_drop: assert property (MEM_REQ_OUT && MEM_ACK_IN |=> !MEM_REQ_OUT)
		else $error("request kept");
	chk_burst_len: assert property (
		MEM_REQ_OUT |-> MEM_BURST_LEN_OUT == 1 || MEM_BURST_LEN_OUT == W)
		else $error("bad burst length");
	chk_line_base: assert property (
		$rose(MEM_REQ_OUT) && MEM_BURST_LEN_OUT != 1 |-> MEM_ADDR_OUT % LINE_BYTES == 0)
		else $error("burst not line aligned");
	chk_beat_step: assert property (
		MEM_VALID_IN && MEM_BURST_LEN_OUT != 1 && (MEM_ADDR_OUT >> 2) % W != W - 1
		|=> MEM_ADDR_OUT == $past(MEM_ADDR_OUT) + 32'h4)
		else $error("beat address step");
endmodule
bind dclf_top dclf_top_asserts #(.LINE_BYTES(LINE_BYTES)) i_chk (
	.CLOCK_IN(CLOCK_IN),
	.RSTN_IN(RSTN_IN),
	.PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN),
	.PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT),
	.MEM_REQ_OUT(MEM_REQ_OUT),
	.MEM_ADDR_OUT(MEM_ADDR_OUT),
	.MEM_BURST_LEN_OUT(MEM_BURST_LEN_OUT),
	.MEM_ACK_IN(MEM_ACK_IN),
	.MEM_VALID_IN(MEM_VALID_IN)
);
`default_nettype wire

//--- bench/dclf_mem_model.sv
// Memory slave answering fill requests.
// Assumes the fill engine's clock.
`timescale 1ns/1ns
`default_nettype none
module dclf_mem_model (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic req_in,
	input wire logic [3:0] len_in,
	input wire logic [31:0] addr_in,
	input wire logic slow_in,
	output logic ack_out,
	output logic valid_out,
	output logic [31:0] rdata_out
);
	logic [3:0] left;
	logic [31:0] cur;
	logic gap;
	always @(posedge clk_in) begin
		ack_out <= 1'b0;
		valid_out <= 1'b0;
		rdata_out <= ~rdata_out;
		gap <= ~gap & slow_in;
		if (!rstn_in) begin
			left <= 4'h0;
			rdata_out <= 32'h0;
			gap <= 1'b0;
		end else if (req_in && !ack_out && left == 4'h0) begin
			ack_out <= 1'b1;
			left <= len_in;
			cur <= addr_in;
		end else if (left != 4'h0 && !gap) begin
			valid_out <= 1'b1;
			rdata_out <= cur ^ 32'h5a5a_0000;
			cur <= cur + 32'h4;
			left <= left - 4'h1;
		end
	end
endmodule
`default_nettype wire

//--- bench/dclf_top_test.sv
// Self-checking bench for the fill engine.
// Assumes the memory model on the fill port.
`timescale 1ns/1ns
`default_nettype none
module dclf_top_test;
	logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pw = 1'b0, slow = 1'b0;
	logic prdy, perr, er, mreq, mack, mval;
	logic [7:0] pa = 8'h00;
	logic [31:0] pd = 32'h0, prd, mad, mrd, r, got_a;
	logic [3:0] mlen, got_l;
	int fails = 0, checked = 0;
	dclf_top i_dut (.CLOCK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(pd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
		.PSLVERR_OUT(perr), .MEM_REQ_OUT(mreq), .MEM_ADDR_OUT(mad), .MEM_BURST_LEN_OUT(mlen),
		.MEM_ACK_IN(mack), .MEM_VALID_IN(mval), .MEM_RDATA_IN(mrd));
	dclf_mem_model i_mem (.clk_in(clk), .rstn_in(rstn), .req_in(mreq), .len_in(mlen),
		.addr_in(mad), .slow_in(slow), .ack_out(mack), .valid_out(mval), .rdata_out(mrd));
	initial forever #10 clk = ~clk;
	task automatic conclude();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pw <= w;
		pa <= a;
		pd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			conclude();
		end
		r = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		// Idle edge so the next call never re-raises psel in this step
		@(posedge clk);
	endtask
	task automatic fill(input logic b, input logic [31:0] miss, input logic [3:0] len);
		int k;
		apb(1'b1, dclf_pkg::OFS_MISS_ADDR, miss);
		apb(1'b1, dclf_pkg::OFS_CTRL, {30'h0, b, 1'b1});
		// Request stands until acknowledged: take its address and length
		k = 0;
		while (mreq !== 1'b1 && k < 20) begin
			@(posedge clk);
			k++;
		end
		if (k >= 20) begin
			fails++;
			conclude();
		end
		got_a = mad;
		got_l = mlen;
		k = 0;
		do begin
			apb(1'b0, dclf_pkg::OFS_STATUS, 32'h0);
			k++;
		end while (r[1:0] !== 2'b10 && k < 200);
		if (k >= 200) begin
			fails++;
			conclude();
		end
		chk(got_a, miss & 32'hffff_ffe0);
		chk({28'h0, got_l}, {28'h0, len});
		for (k = 0; k < 8; k++) begin
			apb(1'b1, dclf_pkg::OFS_FILL_DATA, 32'(k));
			apb(1'b0, dclf_pkg::OFS_FILL_DATA, 32'h0);
			chk(r, ((miss & 32'hffff_ffe0) + (32'(k) << 2)) ^ 32'h5a5a_0000);
		end
	endtask
	task automatic t_regs();
		chk({28'h0, mlen}, 32'h1);
		apb(1'b0, dclf_pkg::OFS_CTRL, 32'h0);
		chk(r, dclf_pkg::CTRL_RESET);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, dclf_pkg::OFS_CONFIG, 32'h0);
		chk(r, {12'h0, 4'h1, 4'h8, 6'h20, 6'h04});
		$display("test regs done");
	endtask
	task automatic t_burst();
		fill(1'b1, 32'h108, 4'h8);
		apb(1'b0, dclf_pkg::OFS_CTRL, 32'h0);
		chk(r, 32'h1 << dclf_pkg::CTRL_BURST_BIT);
		$display("test burst done");
	endtask
	task automatic t_single();
		slow <= 1'b1;
		fill(1'b0, 32'h21c, 4'h1);
		$display("test single done");
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_burst();
		t_single();
		conclude();
	end
endmodule
`default_nettype wire
